// ---- rtl/pio_pkg.sv ----
/*
  pio_pkg: constants for the parallel port pin mux.
  assumes: one synchronous clock domain, eight-bit ports.
*/
package pio_pkg;
  // ************************************************
  // widths and reset values
  // ************************************************
  localparam int          NPORT      = 4;
  localparam int          W          = 8;
  localparam logic [7:0]  DIR_RST    = 8'h00;
  localparam logic [7:0]  SLEW_RST   = 8'hFF;
  localparam logic [7:0]  DRIVE_RST  = 8'h00;
  localparam logic [7:0]  PULL_RST   = 8'h00;
  localparam logic [7:0]  DATA_RST   = 8'h00;
  // implemented bits per port a..d
  localparam logic [7:0]  IMPL_A     = 8'hFF;
  localparam logic [7:0]  IMPL_B     = 8'hFF;
  localparam logic [7:0]  IMPL_C     = 8'h7F;
  localparam logic [7:0]  IMPL_D     = 8'hFF;
  // port c peripheral bit positions
  localparam int          C_RXD_BIT  = 5;
  localparam int          C_TXD_BIT  = 3;
  localparam int          C_CLKO_BIT = 2;
  localparam int          C_SDA_BIT  = 1;
  localparam int          C_SCL_BIT  = 0;
  // port d timer clock input bit positions
  localparam int          D_TCLK1_BIT = 6;
  localparam int          D_TCLK2_BIT = 4;
  // register select codes
  typedef enum logic [2:0] {
    PIO_SEL_DATA,
    PIO_SEL_DIR,
    PIO_SEL_PULL,
    PIO_SEL_SLEW,
    PIO_SEL_DRIVE
  } pio_sel_t;
endpackage

// ---- rtl/pio_if.sv ----
/*
  pio_if: per-port register and override bundle.
  assumes: driven by pio_top, consumed by pio_pin_slice.
*/
`timescale 1ns/100ps
interface pio_if;
  logic [7:0] impl;
  logic [7:0] dir;
  logic [7:0] data;
  logic [7:0] pull;
  logic [7:0] ana_en;
  logic [7:0] per_en;
  logic [7:0] per_oe;
  logic [7:0] per_out;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pull_on;
  logic [7:0] rd_data;
  modport top
  (
    output impl, dir, data, pull, ana_en, per_en, per_oe, per_out, pin_in,
    input  pin_out, pin_oe, pull_on, rd_data
  );
  modport slice
  (
    input  impl, dir, data, pull, ana_en, per_en, per_oe, per_out, pin_in,
    output pin_out, pin_oe, pull_on, rd_data
  );
endinterface

// ---- rtl/pio_pin_slice.sv ----
/*
  pio_pin_slice: pin mux for one eight-bit port.
  assumes: register values held in pio_top; purely combinational.
*/
`timescale 1ns/100ps
module pio_pin_slice
(
  pio_if.slice p
);
  logic [7:0] dig_en;
  logic [7:0] per_live;

  // analog beats any digital claim
  assign dig_en   = p.impl & ~p.ana_en;
  assign per_live = dig_en & p.per_en;

  assign p.pin_oe  = (per_live & p.per_oe) | (dig_en & ~p.per_en & p.dir);
  assign p.pin_out = p.impl & ((per_live & p.per_oe & p.per_out)
                     | (~(per_live & p.per_oe) & p.data));
  // pullup off when driven or analog
  assign p.pull_on = dig_en & p.pull & ~p.pin_oe;
  assign p.rd_data = dig_en & ((p.dir & p.data) | (~p.dir & p.pin_in));
endmodule

// ---- rtl/pio_top.sv ----
/*
  pio_top: parallel ports a..d with peripheral pin sharing.
  assumes: cpu access is a one-cycle write strobe plus a combinational
  read; pins and peripheral controls are synchronous to clk.
*/
// Contract
// - provide the general-purpose pins, each one under software control
// - peripheral sharing off after reset, pio owns every pin
// - direction bits reset to zero, all pins inputs
// - slew limit bits reset to one
// - drive strength bits reset to zero, low drive
// - pullup enable bits reset to zero
// - every input pin has its own pullup enable
// - every output has its own slew limit control
// - data, direction, and separate pullup, slew, drive registers per port
// - port a eight pure gpio pins
// - port b analog-enabled pins lose gpio function
// - port c seven pins: rxd 5, txd 3, clkout 2, sda 1, scl 0
// - port d shares analog, keyboard and timer clock inputs
// - enabled peripheral overrides pin direction
// - enabled peripheral output value drives the pin
// - analog wins over digital peripheral on same pin
// - data read: pin level for inputs, latch for outputs
// - analog-enabled bits read zero
// - pullup off for outputs and analog pins
`timescale 1ns/100ps
module pio_top
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // cpu register access
  input  wire logic         wr_en,
  input  wire logic [1:0]   wr_port,
  input  wire logic [2:0]   wr_sel,
  input  wire logic [7:0]   wr_data,
  input  wire logic [1:0]   rd_port,
  input  wire logic [2:0]   rd_sel,
  output logic      [7:0]   rd_data,
  // pins, flattened port d..a
  input  wire logic [31:0]  pin_in,
  output logic      [31:0]  pin_out,
  output logic      [31:0]  pin_oe,
  output logic      [31:0]  pin_pullup,
  output logic      [31:0]  pin_slew,
  output logic      [31:0]  pin_drive,
  // analog converter channel enables
  input  wire logic [7:0]   adc_en_b,
  input  wire logic [7:0]   adc_en_d,
  // second serial interface
  input  wire logic         ser_rx_en,
  input  wire logic         ser_tx_en,
  input  wire logic         ser_txd,
  output logic              ser_rxd,
  // i2c
  input  wire logic         i2c_en,
  input  wire logic         i2c_sda_oe,
  input  wire logic         i2c_scl_oe,
  output logic              i2c_sda_in,
  output logic              i2c_scl_in,
  // clock output
  input  wire logic         clk_out_en,
  input  wire logic         clk_out_val,
  // keyboard inputs and timer clocks on port d
  input  wire logic [7:0]   kbd_en_d,
  input  wire logic         tmr1_clk_en,
  input  wire logic         tmr2_clk_en,
  output logic      [7:0]   kbd_in_d,
  output logic              tmr1_clk_in,
  output logic              tmr2_clk_in
);
  // ************************************************
  // register state
  // ************************************************
  logic [7:0] data_r  [pio_pkg::NPORT];
  logic [7:0] dir_r   [pio_pkg::NPORT];
  logic [7:0] pull_r  [pio_pkg::NPORT];
  logic [7:0] slew_r  [pio_pkg::NPORT];
  logic [7:0] drive_r [pio_pkg::NPORT];
  logic [7:0] impl    [pio_pkg::NPORT];
  logic [7:0] ana     [pio_pkg::NPORT];
  logic [7:0] pen     [pio_pkg::NPORT];
  logic [7:0] poe     [pio_pkg::NPORT];
  logic [7:0] pout    [pio_pkg::NPORT];
  logic [7:0] rd_v    [pio_pkg::NPORT];
  logic [7:0] pull_v  [pio_pkg::NPORT];

  assign impl[0] = pio_pkg::IMPL_A;
  assign impl[1] = pio_pkg::IMPL_B;
  assign impl[2] = pio_pkg::IMPL_C;
  assign impl[3] = pio_pkg::IMPL_D;

  // ************************************************
  // register writes
  // ************************************************
  // per-pin writable registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < pio_pkg::NPORT; i++)
      begin
        data_r[i]  <= pio_pkg::DATA_RST;
        dir_r[i]   <= pio_pkg::DIR_RST;
        pull_r[i]  <= pio_pkg::PULL_RST;
        slew_r[i]  <= pio_pkg::SLEW_RST;
        drive_r[i] <= pio_pkg::DRIVE_RST;
      end
    end
    else if (wr_en)
    begin
      case (pio_pkg::pio_sel_t'(wr_sel))
        pio_pkg::PIO_SEL_DATA:  data_r[wr_port]  <= wr_data & impl[wr_port];
        pio_pkg::PIO_SEL_DIR:   dir_r[wr_port]   <= wr_data & impl[wr_port];
        pio_pkg::PIO_SEL_PULL:  pull_r[wr_port]  <= wr_data & impl[wr_port];
        pio_pkg::PIO_SEL_SLEW:  slew_r[wr_port]  <= wr_data & impl[wr_port];
        pio_pkg::PIO_SEL_DRIVE: drive_r[wr_port] <= wr_data & impl[wr_port];
        default:                ;
      endcase
    end
  end

  // ************************************************
  // peripheral claims per port
  // ************************************************
  // peripheral enables are zero while their owners sit in reset
  always_comb
  begin
    for (int i = 0; i < pio_pkg::NPORT; i++)
    begin
      ana[i]  = 8'h00;
      pen[i]  = 8'h00;
      poe[i]  = 8'h00;
      pout[i] = 8'h00;
    end
    ana[1] = adc_en_b;
    pen[2][pio_pkg::C_RXD_BIT]  = ser_rx_en;
    pen[2][pio_pkg::C_TXD_BIT]  = ser_tx_en;
    poe[2][pio_pkg::C_TXD_BIT]  = 1'b1;
    pout[2][pio_pkg::C_TXD_BIT] = ser_txd;
    pen[2][pio_pkg::C_CLKO_BIT]  = clk_out_en;
    poe[2][pio_pkg::C_CLKO_BIT]  = 1'b1;
    pout[2][pio_pkg::C_CLKO_BIT] = clk_out_val;
    // open-drain: drive low only while asserting
    pen[2][pio_pkg::C_SDA_BIT] = i2c_en;
    poe[2][pio_pkg::C_SDA_BIT] = i2c_sda_oe;
    pen[2][pio_pkg::C_SCL_BIT] = i2c_en;
    poe[2][pio_pkg::C_SCL_BIT] = i2c_scl_oe;
    // port d analog, keyboard, timer clocks
    ana[3] = adc_en_d;
    pen[3] = kbd_en_d;
    pen[3][pio_pkg::D_TCLK1_BIT] = kbd_en_d[pio_pkg::D_TCLK1_BIT]
                                   | tmr1_clk_en;
    pen[3][pio_pkg::D_TCLK2_BIT] = kbd_en_d[pio_pkg::D_TCLK2_BIT]
                                   | tmr2_clk_en;
  end

  // ************************************************
  // per-port pin slices
  // ************************************************
  for (genvar g = 0; g < pio_pkg::NPORT; g++)
  begin : g_port
    pio_if pif ();
    assign pif.impl    = impl[g];
    assign pif.dir     = dir_r[g];
    assign pif.data    = data_r[g];
    assign pif.pull    = pull_r[g];
    assign pif.ana_en  = ana[g] & impl[g];
    assign pif.per_en  = pen[g] & impl[g];
    assign pif.per_oe  = poe[g];
    assign pif.per_out = pout[g];
    assign pif.pin_in  = pin_in[g*8 +: 8];
    pio_pin_slice u_slice
    (
      .p (pif)
    );
    assign pin_out[g*8 +: 8]    = pif.pin_out;
    assign pin_oe[g*8 +: 8]     = pif.pin_oe;
    assign pin_pullup[g*8 +: 8] = pif.pull_on;
    // c7 slew flop resets high, hidden here
    assign pin_slew[g*8 +: 8]   = slew_r[g] & impl[g];
    assign pin_drive[g*8 +: 8]  = drive_r[g];
    assign rd_v[g]              = pif.rd_data;
    assign pull_v[g]            = pif.pull_on;
  end

  // ************************************************
  // read path and peripheral inputs
  // ************************************************
  // data readback masked in slice
  always_comb
  begin
    case (pio_pkg::pio_sel_t'(rd_sel))
      pio_pkg::PIO_SEL_DATA:  rd_data = rd_v[rd_port];
      pio_pkg::PIO_SEL_DIR:   rd_data = dir_r[rd_port];
      pio_pkg::PIO_SEL_PULL:  rd_data = pull_r[rd_port];
      pio_pkg::PIO_SEL_SLEW:  rd_data = slew_r[rd_port] & impl[rd_port];
      pio_pkg::PIO_SEL_DRIVE: rd_data = drive_r[rd_port];
      default:                rd_data = 8'h00;
    endcase
  end

  // analog pins give digital peripherals a zero
  assign ser_rxd     = pin_in[16 + pio_pkg::C_RXD_BIT];
  assign i2c_sda_in  = pin_in[16 + pio_pkg::C_SDA_BIT];
  assign i2c_scl_in  = pin_in[16 + pio_pkg::C_SCL_BIT];
  assign kbd_in_d    = pin_in[31:24] & ~adc_en_d;
  assign tmr1_clk_in = pin_in[24 + pio_pkg::D_TCLK1_BIT]
                       & ~adc_en_d[pio_pkg::D_TCLK1_BIT];
  assign tmr2_clk_in = pin_in[24 + pio_pkg::D_TCLK2_BIT]
                       & ~adc_en_d[pio_pkg::D_TCLK2_BIT];

  // ************************************************
  // checks
  // ************************************************
  // analog pin never driven
  a_analog_no_drive: assert property (
    @(posedge clk) disable iff (reset)
    (pin_oe[31:24] & adc_en_d) == 8'h00) else $error("analog pin driven");
  a_portb_analog: assert property (
    @(posedge clk) disable iff (reset)
    (pin_oe[15:8] & adc_en_b) == 8'h00) else $error("port b analog driven");
  a_pullup_output: assert property (
    @(posedge clk) disable iff (reset)
    (pin_pullup & pin_oe) == 32'h0) else $error("pullup on output");
  a_unimpl_quiet: assert property (
    @(posedge clk) disable iff (reset)
    !pin_oe[23] && !pin_pullup[23] && !pin_slew[23])
    else $error("port c bit 7 active");
  a_txd_follow: assert property (
    @(posedge clk) disable iff (reset)
    ser_tx_en |-> pin_oe[19] && pin_out[19] == ser_txd)
    else $error("txd not from serial");
  a_kbd_input: assert property (
    @(posedge clk) disable iff (reset)
    (pin_oe[31:24] & kbd_en_d) == 8'h00) else $error("keyboard pin driven");
  a_dir_write: assert property (
    @(posedge clk) disable iff (reset)
    wr_en && wr_port == 2'h0 && wr_sel == 3'h1
    |=> pin_oe[7:0] == $past(wr_data)) else $error("port a dir not taken");
  a_read_latch: assert property (
    @(posedge clk) disable iff (reset)
    rd_sel == 3'h0 && rd_port == 2'h0
    |-> rd_data == ((dir_r[0] & data_r[0]) | (~dir_r[0] & pin_in[7:0])))
    else $error("port a readback wrong");
  a_slew_reset: assert property (
    @(posedge clk)
    $fell(reset) |-> pin_slew == 32'hFF7FFFFF) else $error("slew reset");
  a_reset_outputs: assert property (
    @(posedge clk)
    $fell(reset) |-> pin_oe == 32'h0 && pin_pullup == 32'h0
    && pin_drive == 32'h0) else $error("pins not idle after reset");
  a_analog_pull_off: assert property (
    @(posedge clk) disable iff (reset)
    ((pull_v[1] & adc_en_b) | (pull_v[3] & adc_en_d)) == 8'h00)
    else $error("pullup on analog pin");
  a_clkout_follow: assert property (
    @(posedge clk) disable iff (reset)
    clk_out_en |-> pin_oe[18] && pin_out[18] == clk_out_val)
    else $error("clock output not on pin");
  a_i2c_low_only: assert property (
    @(posedge clk) disable iff (reset)
    i2c_en |-> pin_oe[17] == i2c_sda_oe && pin_oe[16] == i2c_scl_oe
    && !(pin_oe[17] && pin_out[17])) else $error("i2c pin driven high");
  a_analog_read_zero: assert property (
    @(posedge clk) disable iff (reset)
    rd_sel == 3'h0 && rd_port[0]
    |-> (rd_data & (rd_port[1] ? adc_en_d : adc_en_b)) == 8'h00)
    else $error("analog bit read nonzero");
  a_porta_pure: assert property (
    @(posedge clk) disable iff (reset)
    pin_oe[7:0] == dir_r[0] && pin_pullup[7:0] == (pull_r[0] & ~dir_r[0]))
    else $error("port a not pure gpio");
  a_slew_write: assert property (
    @(posedge clk) disable iff (reset)
    wr_en && wr_port == 2'h3 && wr_sel == 3'h3
    |=> pin_slew[31:24] == $past(wr_data)) else $error("slew not taken");
  a_unimpl_read: assert property (
    @(posedge clk) disable iff (reset)
    rd_port == 2'h2 |-> !rd_data[7]) else $error("port c bit 7 read high");

  c_analog_claim: cover property (@(posedge clk) |adc_en_d && |kbd_en_d);
  c_tx_active:    cover property (@(posedge clk) ser_tx_en && ser_txd);
  c_pullup_on:    cover property (@(posedge clk) |pin_pullup);
  c_dir_out:      cover property (@(posedge clk) |pin_oe[7:0]);
  c_i2c_drive:    cover property (@(posedge clk) i2c_en && i2c_sda_oe);
endmodule

// ---- verification/pio_pin_model.sv ----
/*
  pio_pin_model: pads and outside drivers of the port pins.
  assumes: bench drives ext_en/ext_val; pin_oe high = device drives.
*/
`timescale 1ns/100ps
module pio_pin_model
(
  // clock
  clk,
  // device side
  pin_out,
  pin_oe,
  pin_pullup,
  // outside drivers
  ext_en,
  ext_val,
  // pad level
  pin_lvl
);
  input  wire logic        clk;
  input  wire logic [31:0] pin_out;
  input  wire logic [31:0] pin_oe;
  input  wire logic [31:0] pin_pullup;
  input  wire logic [31:0] ext_en;
  input  wire logic [31:0] ext_val;
  output logic      [31:0] pin_lvl;
  logic             [31:0] float_r = 32'h5555_5555;
  // floating pads wander so a stale read cannot pass by luck
  always @(posedge clk)
    float_r <= ~float_r;
  // device drive wins, pullup only when undriven
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      if (pin_oe[i])
        pin_lvl[i] = pin_out[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_val[i];
      else if (pin_pullup[i])
        pin_lvl[i] = 1'b1;
      else
        pin_lvl[i] = float_r[i];
    end
  end
endmodule

// ---- verification/parallel_io_port_mux_tb.sv ----
/*
  parallel_io_port_mux_tb: self-checking bench for pio_top.
  assumes: pio_pin_model resolves the pads; 100 ns clock.
*/
`timescale 1ns/100ps
module parallel_io_port_mux_tb;
  typedef struct packed
  {
    logic [1:0] port;
    logic [2:0] sel;
    logic [7:0] data;
    logic [7:0] exp;
  } pio_row_t;
  logic        clk, reset, wr_en;
  logic [1:0]  wr_port, rd_port;
  logic [2:0]  wr_sel, rd_sel;
  logic [7:0]  wr_data, rd_data, rv;
  logic [31:0] pin_lvl, pin_out, pin_oe, pin_pullup, pin_slew, pin_drive;
  logic [31:0] ext_en, ext_val;
  logic [7:0]  adc_en_b, adc_en_d, kbd_en_d, kbd_in_d;
  logic        ser_rx_en, ser_tx_en, ser_txd, ser_rxd;
  logic        i2c_en, i2c_sda_oe, i2c_scl_oe, i2c_sda_in, i2c_scl_in;
  logic        clk_out_en, clk_out_val, tmr1_clk_en, tmr2_clk_en;
  logic        tmr1_clk_in, tmr2_clk_in;
  int          err_total, n_checks;
  pio_row_t    rows [8] = '{
    '{2'h0, pio_pkg::PIO_SEL_DIR,   8'h0F, 8'h0F},
    '{2'h0, pio_pkg::PIO_SEL_DATA,  8'hA5, 8'hC5},
    '{2'h2, pio_pkg::PIO_SEL_DIR,   8'hFF, pio_pkg::IMPL_C},
    '{2'h1, pio_pkg::PIO_SEL_PULL,  8'h3C, 8'h3C},
    '{2'h3, pio_pkg::PIO_SEL_SLEW,  8'h0F, 8'h0F},
    '{2'h2, pio_pkg::PIO_SEL_DRIVE, 8'h81, 8'h01},
    '{2'h0, 3'h5,                   8'hFF, 8'h00},
    '{2'h3, pio_pkg::PIO_SEL_DIR,   8'hFF, 8'hFF}};

  pio_top dut (.clk(clk), .reset(reset), .wr_en(wr_en), .wr_port(wr_port),
    .wr_sel(wr_sel), .wr_data(wr_data), .rd_port(rd_port), .rd_sel(rd_sel),
    .rd_data(rd_data), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_slew(pin_slew), .pin_drive(pin_drive),
    .adc_en_b(adc_en_b), .adc_en_d(adc_en_d), .ser_rx_en(ser_rx_en),
    .ser_tx_en(ser_tx_en), .ser_txd(ser_txd), .ser_rxd(ser_rxd),
    .i2c_en(i2c_en), .i2c_sda_oe(i2c_sda_oe), .i2c_scl_oe(i2c_scl_oe),
    .i2c_sda_in(i2c_sda_in), .i2c_scl_in(i2c_scl_in),
    .clk_out_en(clk_out_en), .clk_out_val(clk_out_val),
    .kbd_en_d(kbd_en_d), .tmr1_clk_en(tmr1_clk_en),
    .tmr2_clk_en(tmr2_clk_en), .kbd_in_d(kbd_in_d),
    .tmr1_clk_in(tmr1_clk_in), .tmr2_clk_in(tmr2_clk_in));
  pio_pin_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .pin_lvl(pin_lvl));

  // ************************************************
  // shared tasks
  // ************************************************
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] p, input logic [2:0] s,
                    input logic [7:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_port <= p;
    wr_sel  <= s;
    wr_data <= d;
    @(posedge clk);
    wr_en   <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [1:0] p, input logic [2:0] s);
    @(posedge clk);
    rd_port <= p;
    rd_sel  <= s;
    @(negedge clk);
    rv = rd_data;
  endtask
  task automatic check_reset;
    chk("oe", pin_oe, 32'h0000_0000);
    chk("pullup", pin_pullup, 32'h0000_0000);
    chk("drive", pin_drive, 32'h0000_0000);
    chk("slew", pin_slew, 32'hFF7F_FFFF);
    for (int p = 0; p < 4; p++)
    begin
      rd(p[1:0], pio_pkg::PIO_SEL_DIR);
      chk("dir read", rv, 32'h0000_0000);
    end
    rd(2'h2, pio_pkg::PIO_SEL_SLEW);
    chk("c slew read", rv, pio_pkg::SLEW_RST & pio_pkg::IMPL_C);
    $display("reset test done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // margin of about fifty over the expected sixty or so cycles
  initial
  begin
    #(3000 * 100);
    err_total++;
    $display("watchdog expired");
    end_sim();
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    {reset, wr_en, wr_port, wr_sel, wr_data, rd_port, rd_sel} = '0;
    reset = 1'b1;
    {adc_en_b, adc_en_d, kbd_en_d, ser_rx_en, ser_tx_en, ser_txd} = '0;
    {i2c_en, i2c_sda_oe, i2c_scl_oe, clk_out_en, clk_out_val} = '0;
    {tmr1_clk_en, tmr2_clk_en, err_total, n_checks} = '0;
    ext_en  = 32'hFFFF_FFFF;
    ext_val = 32'hC33C_C3C3;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    check_reset();
    foreach (rows[i])
    begin
      wr(rows[i].port, rows[i].sel, rows[i].data);
      rd(rows[i].port, rows[i].sel);
      chk("row read", rv, rows[i].exp);
    end
    chk("a oe", pin_oe[7:0], 8'h0F);
    chk("a out", pin_out[3:0], 4'h5);
    chk("c oe", pin_oe[23:16], pio_pkg::IMPL_C);
    chk("b pullup", pin_pullup[15:8], 8'h3C);
    chk("d slew", pin_slew[31:24], 8'h0F);
    chk("c drive", pin_drive[23:16], 8'h01);
    chk("a drive", pin_drive[7:0], 8'h00);
    $display("row test done");
    wr(2'h1, pio_pkg::PIO_SEL_DIR, 8'hF0);
    wr(2'h1, pio_pkg::PIO_SEL_DATA, 8'hFF);
    @(posedge clk);
    adc_en_b <= 8'h3C;
    rd(2'h1, pio_pkg::PIO_SEL_DATA);
    chk("b data", rv, 8'hC3);
    chk("b oe", pin_oe[15:8], 8'hC0);
    chk("b pullup off", pin_pullup[15:8], 8'h00);
    $display("analog test done");
    @(posedge clk);
    {ser_tx_en, ser_txd, ser_rx_en, clk_out_en} <= 4'hF;
    {clk_out_val, i2c_en, i2c_sda_oe, i2c_scl_oe} <= 4'hE;
    rd(2'h2, pio_pkg::PIO_SEL_DATA);
    chk("c oe", pin_oe[23:16], 8'h5E);
    chk("c out", pin_out[19:17], 3'h6);
    chk("rxd", ser_rxd, 1'b1);
    chk("sda in", i2c_sda_in, 1'b0);
    chk("scl in", i2c_scl_in, 1'b0);
    chk("c data", rv, 8'h00);
    $display("port c test done");
    wr(2'h3, pio_pkg::PIO_SEL_DATA, 8'hFF);
    @(posedge clk);
    {ser_tx_en, ser_rx_en, clk_out_en, i2c_en} <= 4'h0;
    {adc_en_d, kbd_en_d, tmr1_clk_en, tmr2_clk_en} <= {8'h80, 8'h84, 2'h3};
    rd(2'h3, pio_pkg::PIO_SEL_DATA);
    chk("d oe", pin_oe[31:24], 8'h2B);
    chk("d kbd7", kbd_in_d[7], 1'b0);
    chk("tmr1 clk", tmr1_clk_in, 1'b1);
    chk("tmr2 clk", tmr2_clk_in, 1'b0);
    chk("d data", rv, 8'h7F);
    $display("port d test done");
    @(posedge clk);
    {adc_en_b, adc_en_d, kbd_en_d, tmr1_clk_en, tmr2_clk_en} <= '0;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    check_reset();
    end_sim();
  end
endmodule
